// File: hw/ind_regs.svh
// Register map, field positions and frame lengths of the indication port
`ifndef IND_REGS_SVH
`define IND_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_FIFO      8'h08
`define OFS_RX_IND    8'h0C
`define OFS_TX_IND    8'h10
`define OFS_DA_IND    8'h14

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CTRL_RX_EN    0
`define CTRL_TX_EN    1
`define CTRL_DA_EN    2
`define CTRL_FLUSH    3
`define CTRL_RESET    3'h7
`define ST_FULL       0
`define ST_ROLE       1
`define ST_OVF        2
`define ST_LEVEL_LSB  16
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

// ----------------------------------------------------------------------
// Frame lengths, data type code, full margin
// ----------------------------------------------------------------------
`define RX_IND_LEN    13
`define TX_IND_LEN    18
`define DA_IND_LEN    13
`define TYPE_DATA     3'h2
`define PHY_MARGIN    4

`endif

// File: hw/ind_pkg.sv
// Shared types of the indication port
package ind_pkg;
  typedef enum logic [1:0] {
    kind_data, kind_vc_rm, kind_vp_rm, kind_rsvd
  } cell_kind_e;
  typedef enum logic {rx_idle, rx_shift} rx_state_e;
endpackage

// File: hw/ind_frame_rx.sv
// One-wire indication frame receiver, bit 0 first
module ind_frame_rx #(
  parameter int LEN = 13
) (
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic           en,
  input  wire logic           line,
  output logic                frame_valid,
  output logic [LEN-1:0]      frame
);
  localparam int CW = $clog2(LEN);
  localparam logic [CW-1:0] LAST = CW'(LEN - 1);

  logic                line_s1;
  logic                line_s2;
  ind_pkg::rx_state_e  state_reg;
  logic [CW-1:0]       cnt_reg;
  logic [LEN-1:0]      sh_reg;

  // Pin crosses into clk with two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_s1 <= 1'b0;
      line_s2 <= 1'b0;
    end else begin
      line_s1 <= line;
      line_s2 <= line_s1;
    end
  end

  // A 1 while idle is the framing bit; then the fixed length follows
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= ind_pkg::rx_idle;
      cnt_reg     <= '0;
      sh_reg      <= '0;
      frame       <= '0;
      frame_valid <= 1'b0;
    end else begin
      frame_valid <= 1'b0;
      case (state_reg)
        ind_pkg::rx_idle: begin
          if (en && line_s2) begin // RULE21
            sh_reg    <= {line_s2, sh_reg[LEN-1:1]};
            cnt_reg   <= CW'(1);
            state_reg <= ind_pkg::rx_shift;
          end
        end
        ind_pkg::rx_shift: begin
          sh_reg  <= {line_s2, sh_reg[LEN-1:1]};
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == LAST) begin // RULE21
            frame       <= {line_s2, sh_reg[LEN-1:1]};
            frame_valid <= 1'b1;
            state_reg   <= ind_pkg::rx_idle;
          end
        end
        default: state_reg <= ind_pkg::rx_idle;
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_frame_start;
    state_reg == ind_pkg::rx_idle && en && line_s2;
  endsequence
  a_frame_length: assert property ( // RULE21
    s_frame_start |-> ##LEN (frame_valid && frame[0]))
    else $error("frame strobe not at fixed length");
endmodule

// File: hw/ind_port.sv
// Serial indication port: three frame receivers and receive FIFO monitor
// ----------------------------------------------------------------------
// Summary of operation
// RULE1: received-cell frame is 13 bits: channel 12..2, good/bad 1, framing 0
// RULE2: good/bad 0 means lookup hit; 1 means discard the cell
// RULE3: partner sends bit 0 first, framing 1, line idles at 0
// RULE4: transmitted frame 18 bits: chan, loss prio, type, source, ack, framing
// RULE5: type with loss priority classifies rate, data or RM level, FIFO
// RULE6: 000/001 VC RM A/B, 010 data, 100/101 VP RM A/B; prio swaps C/D
// RULE7: source bit 0 partner table, 1 scheduled by this device
// RULE8: send acknowledge 1 means cell goes out, 0 means it does not
// RULE9: partner sends transmitted frame bit 0 first and idles the line at 0
// RULE10: partner sends it once data is ready, matching the offered next cell
// RULE11: partner sends availability frame only on a channel status change
// RULE12: availability frame: channel 12..2, status 1 available, framing 0
// RULE13: partner sends availability frames bit 0 first, line 0 between
// RULE14: partner sends received frame only after its lookup resolves
// RULE15: ATM role: full output high when receive FIFO is full
// RULE16: PHY role: full output high within four bytes of full
// RULE17: byte-wide cell interface, role select picks which pin is enable
// RULE18: cell interface only observes, never drives the handshake
// RULE19: a compliant peer must run the cell handshake itself
// RULE20: cell interface samples on rising edge of its cell clock
// RULE21: receiver starts on a 1 when idle, shifts fixed length, strobes
// ----------------------------------------------------------------------
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`include "ind_regs.svh"

module ind_port #(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  // Serial indication lines and full output
  input  wire logic         rx_cell_ind_line,
  input  wire logic         tx_cell_ind_line,
  input  wire logic         data_avail_line,
  output logic              rx_fifo_full_out,
  // Observed cell bus
  input  wire logic         utopia_role_select,
  input  wire logic         rx_cell_clock,
  input  wire logic [7:0]   rx_cell_data,
  input  wire logic         rx_cell_soc,
  input  wire logic         ut_enb_atm_n,
  input  wire logic         ut_enb_phy_n,
  // Decoded indications
  output logic              rx_ind_valid,
  output logic [10:0]       rx_ind_chan,
  output logic              rx_ind_discard,
  output logic              tx_ind_valid,
  output logic [10:0]       tx_ind_chan,
  output logic              tx_ind_clp,
  output logic [2:0]        tx_ind_type,
  output logic              tx_ind_by_dev,
  output logic              tx_ind_send_ack,
  output logic              tx_ind_out_of_rate,
  output ind_pkg::cell_kind_e tx_ind_kind,
  output logic [1:0]        tx_ind_rm_fifo,
  output logic              da_ind_valid,
  output logic [10:0]       da_ind_chan,
  output logic              da_ind_avail,
  // AXI4-Lite slave
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [7:0]   awaddr,
  input  wire logic         wvalid,
  output logic              wready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  output logic              bvalid,
  input  wire logic         bready,
  output logic [1:0]        bresp,
  input  wire logic         arvalid,
  output logic              arready,
  input  wire logic [7:0]   araddr,
  output logic              rvalid,
  input  wire logic         rready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int LW = $clog2(FIFO_DEPTH + 1);
  localparam logic [LW-1:0] LVL_MAX  = LW'(FIFO_DEPTH);
  localparam logic [LW-1:0] LVL_NEAR = LW'(FIFO_DEPTH - `PHY_MARGIN);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [7:0] word_of(input logic [7:0] a);
    return {a[7:2], 2'h0};
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return word_of(a) <= `OFS_DA_IND;
  endfunction

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    return (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic ind_pkg::cell_kind_e kind_of(input logic [2:0] t);
    case (t)
      3'h0, 3'h1: return ind_pkg::kind_vc_rm;
      `TYPE_DATA: return ind_pkg::kind_data;
      3'h4, 3'h5: return ind_pkg::kind_vp_rm;
      default:    return ind_pkg::kind_rsvd;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Serial frame receivers
  // ----------------------------------------------------------------------
  logic [2:0]              ctrl_reg;
  logic                    rx_fv;
  logic                    tx_fv;
  logic                    da_fv;
  logic [`RX_IND_LEN-1:0]  rx_fr;
  logic [`TX_IND_LEN-1:0]  tx_fr;
  logic [`DA_IND_LEN-1:0]  da_fr;

  ind_frame_rx #(.LEN(`RX_IND_LEN)) u_rx_ind (
    .clk         (clk),
    .rstn        (rstn),
    .en          (ctrl_reg[`CTRL_RX_EN]),
    .line        (rx_cell_ind_line),
    .frame_valid (rx_fv),
    .frame       (rx_fr)
  );

  ind_frame_rx #(.LEN(`TX_IND_LEN)) u_tx_ind (
    .clk         (clk),
    .rstn        (rstn),
    .en          (ctrl_reg[`CTRL_TX_EN]),
    .line        (tx_cell_ind_line),
    .frame_valid (tx_fv),
    .frame       (tx_fr)
  );

  ind_frame_rx #(.LEN(`DA_IND_LEN)) u_da_ind (
    .clk         (clk),
    .rstn        (rstn),
    .en          (ctrl_reg[`CTRL_DA_EN]),
    .line        (data_avail_line),
    .frame_valid (da_fv),
    .frame       (da_fr)
  );

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_ind_valid   <= 1'b0;
      rx_ind_chan    <= '0;
      rx_ind_discard <= 1'b0;
    end else begin
      rx_ind_valid <= rx_fv;
      if (rx_fv) begin
        rx_ind_chan    <= rx_fr[12:2]; // RULE1
        rx_ind_discard <= rx_fr[1]; // RULE2
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_ind_valid       <= 1'b0;
      tx_ind_chan        <= '0;
      tx_ind_clp         <= 1'b0;
      tx_ind_type        <= '0;
      tx_ind_by_dev      <= 1'b0;
      tx_ind_send_ack    <= 1'b0;
      tx_ind_out_of_rate <= 1'b0;
      tx_ind_kind        <= ind_pkg::kind_vc_rm;
      tx_ind_rm_fifo     <= '0;
    end else begin
      tx_ind_valid <= tx_fv;
      if (tx_fv) begin
        tx_ind_chan        <= tx_fr[17:7]; // RULE4
        tx_ind_clp         <= tx_fr[6];
        tx_ind_type        <= tx_fr[5:3];
        tx_ind_by_dev      <= tx_fr[2]; // RULE7
        tx_ind_send_ack    <= tx_fr[1]; // RULE8
        tx_ind_out_of_rate <= tx_fr[6]; // RULE5
        tx_ind_kind        <= kind_of(tx_fr[5:3]); // RULE6
        // Loss priority moves A/B to C/D
        tx_ind_rm_fifo     <= {tx_fr[6], tx_fr[3]}; // RULE6
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      da_ind_valid <= 1'b0;
      da_ind_chan  <= '0;
      da_ind_avail <= 1'b0;
    end else begin
      da_ind_valid <= da_fv;
      if (da_fv) begin
        da_ind_chan  <= da_fr[12:2]; // RULE12
        da_ind_avail <= da_fr[1];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Observed cell bus
  // ----------------------------------------------------------------------
  // The cell clock is sampled, not used as a clock: it must stay well
  // below half of clk or edges are missed.
  logic [12:0] ut_s1;
  logic [12:0] ut_s2;
  logic        ck_s3;
  logic        ck_rise;
  logic        role;
  logic        enb_act;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ut_s1 <= 13'h1800;
      ut_s2 <= 13'h1800;
      ck_s3 <= 1'b0;
    end else begin
      ut_s1 <= {ut_enb_phy_n, ut_enb_atm_n, utopia_role_select,
                rx_cell_clock, rx_cell_soc, rx_cell_data};
      ut_s2 <= ut_s1;
      ck_s3 <= ut_s2[8+1];
    end
  end

  assign ck_rise = ut_s2[9] && !ck_s3; // RULE20
  assign role    = ut_s2[10];
  // Enable is an input pin in either role; nothing here drives the bus
  assign enb_act = role ? !ut_s2[12] : !ut_s2[11]; // RULE17

  // ----------------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------------
  logic [8:0]      mem [FIFO_DEPTH];
  logic [PW-1:0]   wr_ptr;
  logic [PW-1:0]   rd_ptr;
  logic [LW-1:0]   level;
  logic [LW-1:0]   level_next;
  logic            push;
  logic            pop;
  logic            flush;
  logic            ovf_reg;
  logic            ovf_clr;

  assign push = ck_rise && enb_act && level != LVL_MAX; // RULE18

  always_comb begin
    level_next = level;
    if (flush)
      level_next = '0;
    else if (push && !pop)
      level_next = level + 1'b1;
    else if (pop && !push)
      level_next = level - 1'b1;
  end

  always_ff @(posedge clk) begin
    if (push)
      mem[wr_ptr] <= ut_s2[8:0];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      level <= level_next;
      if (flush) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
      end else begin
        if (push)
          wr_ptr <= next_ptr(wr_ptr);
        if (pop)
          rd_ptr <= next_ptr(rd_ptr);
      end
    end
  end

  // A byte lost to a full FIFO wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      ovf_reg <= 1'b0;
    else if (ck_rise && enb_act && level == LVL_MAX)
      ovf_reg <= 1'b1;
    else if (ovf_clr)
      ovf_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      rx_fifo_full_out <= 1'b0;
    else if (role)
      rx_fifo_full_out <= level_next >= LVL_NEAR; // RULE16
    else
      rx_fifo_full_out <= level_next == LVL_MAX; // RULE15
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_wr;
  logic        ctrl_wr;

  assign awready = !aw_hold && !bvalid;
  assign wready  = !w_hold && !bvalid;
  assign arready = !rvalid;
  assign do_wr   = aw_hold && w_hold && !bvalid;
  assign ctrl_wr = do_wr && word_of(aw_addr_reg) == `OFS_CTRL
                   && w_strb_reg[0];
  assign flush   = ctrl_wr && w_data_reg[`CTRL_FLUSH];
  assign ovf_clr = do_wr && word_of(aw_addr_reg) == `OFS_STATUS
                   && w_strb_reg[0] && w_data_reg[`ST_OVF];
  assign pop     = arvalid && arready && !flush
                   && word_of(araddr) == `OFS_FIFO && level != '0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold     <= 1'b0;
      w_hold      <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid      <= 1'b0;
      bresp       <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold     <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold     <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= is_mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      ctrl_reg <= `CTRL_RESET;
    else if (ctrl_wr)
      ctrl_reg <= w_data_reg[2:0];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (word_of(araddr))
        `OFS_CTRL:   rdata <= {29'h0, ctrl_reg};
        `OFS_STATUS: rdata <= {(16 - LW)'(0), level, 13'h0, ovf_reg,
                               role, rx_fifo_full_out};
        `OFS_FIFO:   rdata <= {22'h0, level != '0, mem[rd_ptr]};
        `OFS_RX_IND: rdata <= {19'h0, rx_ind_chan, 1'b0, rx_ind_discard};
        `OFS_TX_IND: rdata <= {14'h0, tx_ind_chan, tx_ind_clp,
                               tx_ind_type, tx_ind_by_dev,
                               tx_ind_send_ack, 1'b0};
        `OFS_DA_IND: rdata <= {19'h0, da_ind_chan, 1'b0, da_ind_avail};
        default:     rdata <= 32'h0;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rx_done;
    rx_fv;
  endsequence
  sequence s_tx_done;
    tx_fv;
  endsequence

  a_rx_chan_field: assert property ( // RULE1
    s_rx_done |=> rx_ind_valid && rx_ind_chan == $past(rx_fr[12:2]))
    else $error("received channel field wrong");
  a_rx_discard_bit: assert property ( // RULE2
    s_rx_done |=> rx_ind_discard == $past(rx_fr[1]))
    else $error("good/bad flag wrong");
  a_tx_chan_field: assert property ( // RULE4
    s_tx_done |=> tx_ind_valid && tx_ind_chan == $past(tx_fr[17:7])
                  && tx_ind_type == $past(tx_fr[5:3]))
    else $error("transmitted fields wrong");
  a_tx_rate_class: assert property ( // RULE5
    s_tx_done |=> tx_ind_out_of_rate == $past(tx_fr[6]))
    else $error("rate class wrong");
  a_tx_type_map: assert property ( // RULE6
    s_tx_done ##0 tx_fr[5:3] == 3'h5 |=>
      tx_ind_kind == ind_pkg::kind_vp_rm
      && tx_ind_rm_fifo == {tx_ind_clp, 1'b1})
    else $error("cell type decode wrong");
  a_tx_sched_src: assert property ( // RULE7
    s_tx_done |=> tx_ind_by_dev == $past(tx_fr[2]))
    else $error("scheduling source wrong");
  a_tx_send_ack: assert property ( // RULE8
    s_tx_done |=> tx_ind_send_ack == $past(tx_fr[1]))
    else $error("send acknowledge wrong");
  a_da_status: assert property ( // RULE12
    da_fv |=> da_ind_valid && da_ind_avail == $past(da_fr[1])
              && da_ind_chan == $past(da_fr[12:2]))
    else $error("availability fields wrong");
  a_full_atm: assert property ( // RULE15
    !role && $stable(role) |-> rx_fifo_full_out == (level == LVL_MAX))
    else $error("full output wrong in ATM role");
  a_full_phy: assert property ( // RULE16
    role && $stable(role) |-> rx_fifo_full_out == (level >= LVL_NEAR))
    else $error("full output wrong in PHY role");
  a_push_on_edge: assert property ( // RULE20
    push |-> ut_s2[9] && !ck_s3 ##1 !push)
    else $error("byte taken without cell clock edge");
  a_push_counts: assert property ( // RULE17
    push && !pop && !flush |=> level == $past(level) + 1'b1)
    else $error("observed byte not counted");
endmodule

// File: tb/ind_partner.sv
// Partner model: controller that sends the three serial indication frames
module ind_partner (
  output logic rx_line,
  output logic tx_line,
  output logic da_line,
  input  wire logic clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_line = 1'b0;
    tx_line = 1'b0;
    da_line = 1'b0;
  end
  // Bit 0 first, one bit per clock, line back to 0 after the frame
  task automatic send(input int s, input logic [17:0] f);
    for (int i = 0; i <= (s == 1 ? 18 : 13); i++) begin
      @(posedge clk);
      if (s == 0) rx_line <= (i < 13) ? f[i] : 1'b0;
      else if (s == 1) tx_line <= (i < 18) ? f[i] : 1'b0;
      else da_line <= (i < 13) ? f[i] : 1'b0;
    end
  endtask
endmodule

// File: tb/tb.sv
// Testbench of the serial indication port
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEPTH = 8;
  logic clk, rstn, role, ccl, soc, enb_n, awvalid, wvalid, bready;
  logic arvalid, rready, full, rxv, rxd, txv, txclp, txdev, txack, txoor;
  logic dav, daa, awready, wready, bvalid, arready, rvalid;
  logic [7:0] cdat, awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [10:0] rxc, txc, dac;
  logic [2:0] txt;
  logic [1:0] txf, bresp, rresp, rs;
  ind_pkg::cell_kind_e txk;
  wire rx_l, tx_l, da_l;
  int failures, checked, cyc;
  logic [15:0] rnd = 16'hC7E6;
  logic [17:0] rxq[$], txq[$], daq[$];
  logic [8:0] cq[$];
  ind_port #(.FIFO_DEPTH(DEPTH)) i_ind_port (.clk(clk), .rstn(rstn),
    .rx_cell_ind_line(rx_l), .tx_cell_ind_line(tx_l),
    .data_avail_line(da_l), .rx_fifo_full_out(full),
    .utopia_role_select(role), .rx_cell_clock(ccl), .rx_cell_data(cdat),
    .rx_cell_soc(soc), .ut_enb_atm_n(enb_n | role),
    .ut_enb_phy_n(enb_n | !role),
    .rx_ind_valid(rxv), .rx_ind_chan(rxc), .rx_ind_discard(rxd),
    .tx_ind_valid(txv), .tx_ind_chan(txc), .tx_ind_clp(txclp),
    .tx_ind_type(txt), .tx_ind_by_dev(txdev), .tx_ind_send_ack(txack),
    .tx_ind_out_of_rate(txoor), .tx_ind_kind(txk), .tx_ind_rm_fifo(txf),
    .da_ind_valid(dav), .da_ind_chan(dac), .da_ind_avail(daa),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));
  ind_partner i_ind_partner (.rx_line(rx_l), .tx_line(tx_l),
    .da_line(da_l), .clk(clk));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] nx();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction
  function automatic logic [1:0] kind_of(input logic [2:0] t);
    case (t)
      3'h2: return 2'h0;
      3'h0, 3'h1: return 2'h1;
      3'h4, 3'h5: return 2'h2;
      default: return 2'h3;
    endcase
  endfunction
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        output logic [1:0] r);
    logic aw, w, b;
    aw = 1'b1; w = 1'b1; b = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; bready <= 1'b1;
    while (!b) begin
      @(negedge clk);
      b = (bvalid === 1'b1);
      r = bresp;
      if (awready === 1'b1) aw = 1'b0;
      if (wready === 1'b1) w = 1'b0;
      @(posedge clk);
      if (!aw) awvalid <= 1'b0;
      if (!w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] r);
    logic ar, got;
    ar = 1'b1; got = 1'b0;
    @(posedge clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    while (!got) begin
      @(negedge clk);
      got = (rvalid === 1'b1);
      v = rdata;
      r = rresp;
      if (arready === 1'b1) ar = 1'b0;
      @(posedge clk);
      if (!ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic snd(input int s, input logic [17:0] f);
    if (s == 0) rxq.push_back(f);
    else if (s == 1) txq.push_back(f);
    else daq.push_back(f);
    i_ind_partner.send(s, f);
  endtask
  // Slow cell clock keeps well inside the synchroniser's reach
  task automatic push(input logic [8:0] v);
    @(posedge clk);
    cdat <= v[7:0]; soc <= v[8]; enb_n <= 1'b0;
    repeat (4) @(posedge clk);
    ccl <= 1'b1;
    repeat (4) @(posedge clk);
    ccl <= 1'b0; enb_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and result monitor
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    logic [17:0] f;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
    if (rxv === 1'b1) begin
      if (rxq.size() == 0) chk("rx_extra", 0, 1);
      else begin
        f = rxq.pop_front();
        chk("rx_chan", f[12:2], rxc);
        chk("rx_discard", f[1], rxd);
      end
    end
    if (txv === 1'b1 && txq.size() > 0) begin
      f = txq.pop_front();
      chk("tx_chan", f[17:7], txc);
      chk("tx_clp", {f[6], f[5:3]}, {txclp, txt});
      chk("tx_src", f[2], txdev);
      chk("tx_ack", f[1], txack);
      chk("tx_rate", f[6], txoor);
      chk("tx_kind", kind_of(f[5:3]), txk);
      chk("tx_fifo", {f[6], f[3]}, txf);
    end
    if (dav === 1'b1 && daq.size() > 0) begin
      f = daq.pop_front();
      chk("da_chan", f[12:2], dac);
      chk("da_avail", f[1], daa);
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0; role = 1'b0; ccl = 1'b0; soc = 1'b0; enb_n = 1'b1;
    cdat = 8'h00; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    axi_rd(8'h00, d, rs);
    chk("ctrl_reset", 32'h7, d);
    axi_rd(8'h40, d, rs);
    chk("rd_unmapped", 2'h2, rs);
    axi_wr(8'h40, 32'h0, rs);
    chk("wr_unmapped", 2'h2, rs);
    fork
      for (int i = 0; i < 6; i++) snd(0, {5'h0, 11'(nx() >> 5), i[0], 1'b1});
      for (int i = 0; i < 16; i++)
        snd(1, {11'(nx() >> 5), i[3:0], 2'(nx() >> 14), 1'b1});
      for (int i = 0; i < 6; i++) snd(2, {5'h0, 11'(nx() >> 5), i[0], 1'b1});
    join
    repeat (30) @(posedge clk);
    chk("pending", 0, rxq.size() + txq.size() + daq.size());
    axi_wr(8'h00, 32'h6, rs);
    i_ind_partner.send(0, 18'h1FFF);
    repeat (30) @(posedge clk);
    axi_wr(8'h00, 32'h7, rs);
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      role <= r[0];
      repeat (6) @(posedge clk);
      for (int k = 1; k <= DEPTH; k++) begin
        cq.push_back(9'(nx() >> 7));
        push(cq[$]);
        chk("full", r ? k >= DEPTH - 4 : k == DEPTH, full);
      end
      while (cq.size() > 0) begin
        axi_rd(8'h08, d, rs);
        chk("fifo", cq.pop_front(), d[8:0]);
      end
      repeat (3) @(posedge clk);
      chk("full_drained", 0, full);
    end
    final_report();
  end
endmodule
